/* design/cvg_pkg.sv */
// Constants and types for the character video generator
package cvg_pkg;
  typedef enum logic [1:0] {
    MODE_WIDE  = 2'b00,
    MODE_EXT   = 2'b01,
    MODE_THIN  = 2'b10,
    MODE_ALPHA = 2'b11
  } disp_mode_t;

  typedef enum logic [1:0] {
    CUR_UL     = 2'b00,
    CUR_UL_BLK = 2'b01,
    CUR_RV     = 2'b10,
    CUR_RV_BLK = 2'b11
  } cursor_mode_t;

  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] FONT_ADR_OFS  = 8'h04;
  localparam logic [7:0] FONT_DAT_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS    = 8'h0c;
  localparam logic [1:0] CTRL_RST      = 2'h3;

  localparam logic [3:0] GLYPH_FIRST   = 4'h1;
  localparam logic [3:0] GLYPH_LAST    = 4'hb;
  localparam logic [3:0] UL_ROW        = 4'hb;
  localparam logic [3:0] ST_ROW_A      = 4'h5;
  localparam logic [3:0] ST_ROW_B      = 4'h6;
  localparam logic [3:0] WIDE_FILL_ROW = 4'hb;
  localparam logic [3:0] WIDE_BAND1_ROW = 4'h3;
  localparam logic [3:0] WIDE_BAND2_ROW = 4'h6;
  localparam logic [3:0] WIDE_BAND3_ROW = 4'h9;
  localparam logic [3:0] THIN_H_ROW    = 4'h5;
  localparam logic [3:0] THIN_END_ROW  = 4'hb;
  localparam logic [1:0] CHAR_OFF_PH   = 2'h3;

  localparam longint CLK_HZ        = 20000000;
  localparam longint CUR_HZ_X1000  = 3750;
  localparam longint BLINK_HALF_CYC = (CLK_HZ * 1000) / (2 * CUR_HZ_X1000);
endpackage

/* design/char_video_generator.sv */
// Character video generator: decode, attributes and dot serializer
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module char_video_generator
  import cvg_pkg::*;
#(
  parameter int unsigned BLINK_HALF = 32'(BLINK_HALF_CYC)
) (
  input  wire logic        mclk_i,                // System clock
  input  wire logic        rst_i,                 // Async reset, high
  input  wire logic        dot_clock_i,           // Video dot clock pin
  input  wire logic        load_shift_select_i,   // Load high, shift low
  input  wire logic [7:0]  char_code_in_i,        // Code or data byte
  input  wire logic [3:0]  row_addr_i,            // Row in block
  input  wire logic        invert_video_i,        // Reverse video
  input  wire logic        retrace_blank_i,       // Retrace blanking
  input  wire logic        char_blank_i,          // Character blank
  input  wire logic        blink_i,               // Blink attribute
  input  wire logic        underline_attr_i,      // Underline
  input  wire logic        strike_attr_i,         // Strike-through
  input  wire logic        attr_latch_en_i,       // Attribute latch enable
  input  wire logic        mode_sel_hi_i,         // Mode select high bit
  input  wire logic        mode_sel_lo_i,         // Mode select low bit
  input  wire logic        cursor_i,              // Cursor at this char
  input  wire logic        wb_cyc_i,              // Wishbone cycle
  input  wire logic        wb_stb_i,              // Wishbone strobe
  input  wire logic        wb_we_i,               // Wishbone write
  input  wire logic [7:0]  wb_adr_i,              // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,              // Wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,              // Wishbone write data
  output logic      [31:0] wb_dat_o,              // Wishbone read data
  output logic             wb_ack_o,              // Wishbone acknowledge
  output logic             video_o                // Serial dot stream
);

  localparam int NS = 24;

  // Pin synchronisers: a bit changes once stages two and three agree
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] s3_q;
  logic [NS-1:0] filt_q;
  logic [NS-1:0] pins_w;

  assign pins_w = {cursor_i, attr_latch_en_i, mode_sel_hi_i,
                   mode_sel_lo_i, blink_i, strike_attr_i,
                   underline_attr_i, char_blank_i, retrace_blank_i,
                   invert_video_i, row_addr_i, char_code_in_i,
                   load_shift_select_i, dot_clock_i};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= pins_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NS; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic       p_cur;
  logic       p_aen;
  logic       p_mhi;
  logic       p_mlo;
  logic       p_blink;
  logic       p_strike;
  logic       p_ul;
  logic       p_char_blank;
  logic       p_rtb;
  logic       p_rev;
  logic [3:0] p_row;
  logic [7:0] p_code;
  logic       p_ls;
  logic       p_dot;

  assign {p_cur, p_aen, p_mhi, p_mlo, p_blink, p_strike, p_ul,
          p_char_blank, p_rtb, p_rev, p_row, p_code, p_ls, p_dot} = filt_q;

  logic ls_prev_q;
  logic dot_prev_q;
  logic ls_fall;
  logic dot_rise;
  logic do_load;
  logic do_shift;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ls_prev_q  <= 1'b0;
      dot_prev_q <= 1'b0;
    end else begin
      ls_prev_q  <= p_ls;
      dot_prev_q <= p_dot;
    end
  end

  assign ls_fall  = ls_prev_q & ~p_ls;
  assign dot_rise = p_dot & ~dot_prev_q;
  assign do_load  = dot_rise & p_ls;
  assign do_shift = dot_rise & ~p_ls;

  // Code, retrace and cursor latch on the falling load/shift edge
  logic [7:0] code_q;
  logic       rtb_q;
  logic       cur_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      code_q <= 8'h00;
      rtb_q  <= 1'b1;
      cur_q  <= 1'b0;
    end else if (ls_fall) begin
      code_q <= p_code;
      rtb_q  <= p_rtb;
      cur_q  <= p_cur;
    end
  end

  // Attribute latch
  logic       rev_q;
  logic       char_blank_q;
  logic       ul_q;
  logic       st_q;
  logic       blink_q;
  disp_mode_t mode_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rev_q   <= 1'b0;
      char_blank_q <= 1'b0;
      ul_q    <= 1'b0;
      st_q    <= 1'b0;
      blink_q <= 1'b0;
      mode_q  <= MODE_WIDE;
    end else if (ls_fall && p_aen) begin
      rev_q   <= p_rev;
      char_blank_q <= p_char_blank;
      ul_q    <= p_ul;
      st_q    <= p_strike;
      blink_q <= p_blink;
      mode_q  <= disp_mode_t'({p_mhi, p_mlo});
    end
  end

  // Blink timebase: phase bit 0 is the cursor rate, phase 3 char off
  logic [31:0] bcnt_q;
  logic [1:0]  phase_q;
  logic        cur_on;
  logic        char_off;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bcnt_q  <= '0;
      phase_q <= 2'h0;
    end else if (bcnt_q == BLINK_HALF - 1) begin
      bcnt_q  <= '0;
      phase_q <= phase_q + 2'h1;
    end else begin
      bcnt_q <= bcnt_q + 32'h1;
    end
  end

  assign cur_on   = phase_q[0];
  assign char_off = (phase_q == CHAR_OFF_PH);

  // Font memory, written by software; index is code and row
  logic [6:0]  font_q [0:2047];
  logic [10:0] font_adr_q;
  logic [6:0]  glyph;

  assign glyph = font_q[{code_q[6:0], p_row}];

  cursor_mode_t cmode_q;

  // Row decode and attribute logic
  logic [7:0] pix;
  logic [7:0] base;
  logic [7:0] row_d;
  logic       line;
  logic       cur_line;
  logic       rev_eff;
  logic       blank_chr;
  logic       wide_bit;
  logic [1:0] band;

  always_comb begin
    pix      = 8'h00;
    wide_bit = 1'b0;
    band     = 2'h0;
    unique case (mode_q)
      MODE_ALPHA: begin
        if (p_row >= GLYPH_FIRST && p_row <= GLYPH_LAST) begin
          pix = {1'b0, glyph};
        end
      end
      MODE_EXT: pix = code_q;
      MODE_THIN: begin
        if (code_q[0] && p_row <= THIN_END_ROW) begin
          pix[4] = 1'b1;
        end
        if (code_q[1] && p_row == THIN_H_ROW) begin
          pix[7:4] = 4'hf;
        end
        if (code_q[2] && p_row == THIN_H_ROW) begin
          pix[3:0] = 4'hf;
        end
      end
      MODE_WIDE: begin
        if (p_row >= WIDE_FILL_ROW) begin
          pix = 8'hff;
        end else begin
          // Rows 0 to 10 form four bands of two segments each
          band     = {1'b0, p_row >= WIDE_BAND1_ROW} +
                     {1'b0, p_row >= WIDE_BAND2_ROW} +
                     {1'b0, p_row >= WIDE_BAND3_ROW};
          wide_bit = code_q[{band, 1'b0}];
          pix[7:4] = {4{wide_bit}};
          wide_bit = code_q[{band, 1'b1}];
          pix[3:0] = {4{wide_bit}};
        end
      end
    endcase
    line = (ul_q && p_row == UL_ROW) ||
           (st_q && (p_row == ST_ROW_A ||
                     p_row == ST_ROW_B));
    cur_line = cur_q && p_row == UL_ROW &&
               (cmode_q == CUR_UL ||
                (cmode_q == CUR_UL_BLK && cur_on));
    rev_eff = rev_q;
    if (cur_q && cmode_q == CUR_RV) begin
      rev_eff = ~rev_q;
    end
    if (cur_q && cmode_q == CUR_RV_BLK && cur_on) begin
      rev_eff = ~rev_q;
    end
    blank_chr = char_blank_q ||
                (blink_q && (cur_q ? ~cur_on : char_off));
    base = blank_chr ? 8'h00 : (line ? 8'hff : pix);
    if (cur_line) begin
      base = 8'hff;
    end
    row_d = rev_eff ? ~base : base;
    if (rtb_q) begin
      row_d = 8'h00;
    end
  end

  // Dot shift register
  logic [7:0] sr_q;
  logic       fill_q;
  logic       video_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sr_q    <= 8'h00;
      fill_q  <= 1'b0;
      video_q <= 1'b0;
    end else if (do_load) begin
      sr_q   <= row_d;
      fill_q <= rev_eff & ~rtb_q;
    end else if (do_shift) begin
      video_q <= sr_q[7];
      sr_q    <= {sr_q[6:0], fill_q};
    end
  end

  assign video_o = video_q;

  // Wishbone slave, one wait state
  logic        req;
  logic        ack_q;
  logic [31:0] rdat_q;

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmode_q    <= cursor_mode_t'(CTRL_RST);
      font_adr_q <= '0;
    end else if (req && wb_we_i) begin
      if (wb_adr_i == CTRL_OFS && wb_sel_i[0]) begin
        cmode_q <= cursor_mode_t'(wb_dat_i[1:0]);
      end
      if (wb_adr_i == FONT_ADR_OFS) begin
        if (wb_sel_i[0]) begin
          font_adr_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          font_adr_q[10:8] <= wb_dat_i[10:8];
        end
      end
      if (wb_adr_i == FONT_DAT_OFS && wb_sel_i[0]) begin
        font_adr_q <= font_adr_q + 11'h1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (req && wb_we_i && wb_adr_i == FONT_DAT_OFS && wb_sel_i[0]) begin
      font_q[font_adr_q] <= wb_dat_i[6:0];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdat_q <= '0;
    end else if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        CTRL_OFS:     rdat_q <= {30'h0, cmode_q};
        FONT_ADR_OFS: rdat_q <= {21'h0, font_adr_q};
        FONT_DAT_OFS: rdat_q <= {25'h0, font_q[font_adr_q]};
        STATUS_OFS:   rdat_q <= {13'h0, phase_q, cur_q, rtb_q,
                                 blink_q, st_q, ul_q, char_blank_q,
                                 rev_q, mode_q, code_q};
        default:      rdat_q <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Checks
  a_load_row: assert property (@(posedge mclk_i) disable iff (rst_i)
    do_load |=> sr_q == $past(row_d))
    else $error("row not loaded");

  a_load_holds_video: assert property (@(posedge mclk_i)
    disable iff (rst_i) do_load |=> $stable(video_q))
    else $error("video moved during load");

  a_shift_msb_first: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    do_shift |=> video_q == $past(sr_q[7]))
    else $error("wrong dot order");

  a_fill_dot: assert property (@(posedge mclk_i) disable iff (rst_i)
    do_shift |=> sr_q[0] == $past(fill_q))
    else $error("wrong filler dot");

  a_retrace_zero: assert property (@(posedge mclk_i)
    disable iff (rst_i) do_load && rtb_q |=> sr_q == 8'h00)
    else $error("retrace not blank");

  a_code_capture: assert property (@(posedge mclk_i)
    disable iff (rst_i) ls_fall |=> code_q == $past(p_code))
    else $error("code not captured");

  a_attr_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(ls_fall && p_aen) |=> $stable(rev_q) && $stable(mode_q))
    else $error("attributes changed");

  a_wide_fill: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_q == MODE_WIDE && p_row >= WIDE_FILL_ROW |-> pix == 8'hff)
    else $error("wide rows not filled");

  a_alpha_edge: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_q == MODE_ALPHA && (p_row == 4'h0 || p_row > GLYPH_LAST)
    |-> pix == 8'h00)
    else $error("glyph outside box");

  a_ack_single: assert property (@(posedge mclk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held");

  c_load: cover property (@(posedge mclk_i) do_load ##[1:20] do_shift);
  c_reverse: cover property (@(posedge mclk_i) do_load && rev_eff);
  c_retrace: cover property (@(posedge mclk_i) do_load && rtb_q);
  c_cursor: cover property (@(posedge mclk_i) do_load && cur_q);

endmodule
`default_nettype wire

/* verification/timing_ctl_model.sv */
// Display timing controller model: drives the pins, collects dot rows
`timescale 1ns/10ps
`default_nettype none
module timing_ctl_model (
  input  wire logic       mclk_i,  // System clock
  input  wire logic       video_i, // Serial dots from the block
  output logic            dot_o,   // Dot clock
  output logic            ls_o,    // Load high, shift low
  output logic      [7:0] code_o,  // Code or data byte
  output logic      [3:0] row_o,   // Row in block
  output logic      [9:0] attr_o,  // Mode, attributes, blank, cursor, enable
  output logic      [9:0] cap_o    // Dots shifted after the last load
);
  initial begin
    dot_o = 1'b0;
    ls_o = 1'b0;
    code_o = 8'h00;
    row_o = 4'h0;
    attr_o = 10'h000;
    cap_o = 10'h000;
  end

  // Dot clock stands low between pulses, high 5 and low at least 5 clocks
  task automatic pulse(input int lo);
    repeat (3) @(posedge mclk_i);
    dot_o <= 1'b1;
    repeat (5) @(posedge mclk_i);
    dot_o <= 1'b0;
    repeat (lo) @(posedge mclk_i);
  endtask

  // One character slot: load, latch the next code, then ten shift dots
  task automatic step(input logic [7:0] c, input logic [9:0] a,
                      input logic [3:0] r);
    @(posedge mclk_i);
    code_o <= c;
    attr_o <= a;
    row_o <= r;
    ls_o <= 1'b1;
    pulse(2);
    ls_o <= 1'b0;
    for (int i = 9; i >= 0; i--) begin
      pulse(5);
      cap_o[i] <= video_i;
    end
  endtask
endmodule
`default_nettype wire

/* verification/char_video_generator_tb.sv */
// Self-checking bench for the character video generator
`timescale 1ns/10ps
`default_nettype none
module char_video_generator_tb;
  import cvg_pkg::*;
  localparam int unsigned BH = 1500;
  localparam logic [9:0] EN = 10'h001, CUR = 10'h002, RET = 10'h004;
  localparam logic [9:0] ST = 10'h008, UL = 10'h010, BL = 10'h020;
  localparam logic [9:0] CB = 10'h040, RV = 10'h080, EXT = 10'h101;
  localparam logic [9:0] THN = 10'h201, ALP = 10'h301, WID = 10'h001;
  logic        mclk_i, rst_i, dot, ls, video, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  code, wb_adr;
  logic [3:0]  row, wb_sel;
  logic [9:0]  attr, cap;
  logic [31:0] wb_wd, wb_rd, rd;
  int          err_total, n_compared;

  char_video_generator #(.BLINK_HALF(BH)) i_char_video_generator (
    .mclk_i(mclk_i), .rst_i(rst_i), .dot_clock_i(dot),
    .load_shift_select_i(ls), .char_code_in_i(code), .row_addr_i(row),
    .invert_video_i(attr[7]), .retrace_blank_i(attr[2]),
    .char_blank_i(attr[6]), .blink_i(attr[5]),
    .underline_attr_i(attr[4]), .strike_attr_i(attr[3]),
    .attr_latch_en_i(attr[0]), .mode_sel_hi_i(attr[9]),
    .mode_sel_lo_i(attr[8]), .cursor_i(attr[1]), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
    .wb_ack_o(wb_ack), .video_o(video));

  timing_ctl_model i_timing_ctl_model (
    .mclk_i(mclk_i), .video_i(video), .dot_o(dot), .ls_o(ls),
    .code_o(code), .row_o(row), .attr_o(attr), .cap_o(cap));

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    bit got;
    got = 1'b0;
    @(posedge mclk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wd <= d;
    for (int n = 0; n < 20 && !got; n++) begin
      @(posedge mclk_i);
      got = (wb_ack === 1'b1);
      rd = wb_rd;
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (!got) begin
      err_total++;
      conclude();
    end
  endtask

  // Two slots: the first latches the code, the second loads and shifts it
  task automatic show(input logic [7:0] c, input logic [9:0] a,
                      input logic [3:0] r, input logic [7:0] d, input bit f);
    i_timing_ctl_model.step(c, a, r);
    i_timing_ctl_model.step(c, a, r);
    @(posedge mclk_i);
    check(32'(cap), 32'({d, f, f}));
  endtask

  task automatic wait_ph(input logic [1:0] ph);
    int n;
    n = 0;
    do begin
      wb(1'b0, STATUS_OFS, 0);
      n++;
    end while (n < 3000 && rd[18:17] !== ph);
    if (rd[18:17] !== ph) begin
      err_total++;
      conclude();
    end
  endtask

  function automatic logic [6:0] fd(input int r);
    return 7'(r * 9 + 3);
  endfunction

  initial begin
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_wd = 32'h0;
    rd = 32'h0;
    err_total = 0;
    n_compared = 0;
    repeat (2) @(posedge mclk_i);
    check(32'(video), 32'h0);
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFS, 0);
    check(rd, 32'(CTRL_RST));
    wb(1'b1, 8'h10, 32'hffffffff);
    wb(1'b0, 8'h10, 0);
    check(rd, 32'h0);
    check(32'(BLINK_HALF_CYC), 32'(64'd20000000 * 2 / 15));
    i_timing_ctl_model.step(8'hff, EXT | RV, 4'h0);
    @(posedge mclk_i);
    check(32'(cap), 32'h0);
    wb(1'b1, FONT_ADR_OFS, {21'h0, 7'h41, 4'h0});
    for (int r = 0; r < 16; r++) wb(1'b1, FONT_DAT_OFS, 32'(fd(r)));
    wb(1'b1, FONT_ADR_OFS, {21'h0, 7'h41, 4'h3});
    wb(1'b0, FONT_DAT_OFS, 0);
    check(rd, 32'(fd(3)));
    for (int r = 0; r < 16; r++) begin
      show(r[0] ? 8'hc1 : 8'h41, ALP, 4'(r),
           (r >= 1 && r <= 11) ? {1'b0, fd(r)} : 8'h00, 0);
    end
    show(8'h41, ALP | RV, 4'h5, ~{1'b0, fd(5)}, 1);
    show(8'ha5, EXT, 4'h7, 8'ha5, 0);
    wb(1'b0, STATUS_OFS, 0);
    check(rd[9:0], {2'b01, 8'ha5});
    show(8'h09, WID, 4'h0, 8'hf0, 0);
    show(8'h09, WID, 4'h4, 8'h0f, 0);
    show(8'h09, WID, 4'h8, 8'h00, 0);
    show(8'h40, WID, 4'h9, 8'hf0, 0);
    show(8'h80, WID, 4'ha, 8'h0f, 0);
    show(8'h00, WID, 4'hb, 8'hff, 0);
    show(8'h00, WID, 4'hf, 8'hff, 0);
    show(8'h07, THN, 4'h5, 8'hff, 0);
    show(8'h01, THN, 4'h2, 8'h10, 0);
    show(8'h02, THN, 4'h5, 8'hf0, 0);
    show(8'h04, THN, 4'h5, 8'h0f, 0);
    show(8'h07, THN, 4'hc, 8'h00, 0);
    show(8'h00, EXT | UL, 4'hb, 8'hff, 0);
    show(8'h00, EXT | UL, 4'ha, 8'h00, 0);
    show(8'h00, WID | ST, 4'h5, 8'hff, 0);
    show(8'h00, EXT | ST, 4'h6, 8'hff, 0);
    show(8'h00, EXT | ST, 4'hb, 8'h00, 0);
    show(8'h00, EXT | ST, 4'h4, 8'h00, 0);
    show(8'hff, EXT | CB, 4'h3, 8'h00, 0);
    show(8'hff, EXT | CB | RV, 4'h3, 8'hff, 1);
    show(8'hff, EXT | RET | RV | UL, 4'hb, 8'h00, 0);
    show(8'h5a, EXT | RV, 4'h1, 8'ha5, 1);
    show(8'h5a, 10'h000, 4'h1, 8'ha5, 1);
    wb(1'b1, CTRL_OFS, 32'h2);
    show(8'h3c, EXT | CUR, 4'h0, 8'hc3, 1);
    wait_ph(2'h2);
    wait_ph(2'h3);
    show(8'h3c, EXT | BL, 4'h0, 8'h00, 0);
    wait_ph(2'h0);
    show(8'h3c, EXT | BL, 4'h0, 8'h3c, 0);
    conclude();
  end
endmodule
`default_nettype wire
